// File: iwd_map.svh
// Register map, field positions, reset values and counts of the decoder
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

`define IWD_SOCKETS 2
`define IWD_MEM_WINS 5
`define IWD_IO_WINS 2
`define IWD_TIM_SETS 2

// Index byte layout
`define IWD_IDX_BANK 7
`define IWD_IDX_SOCK 6

// Per-socket sub-index layout
`define IWD_SUB_MEM_BASE 6'h00
`define IWD_SUB_IO_BASE 6'h14
`define IWD_SUB_TIM_BASE 6'h1c
`define IWD_SUB_STATUS 6'h1e
`define IWD_FLD_CTL 2'h0
`define IWD_FLD_START 2'h1
`define IWD_FLD_END 2'h2
`define IWD_FLD_OFF 2'h3

// Memory window control bits
`define IWD_MC_EN 0
`define IWD_MC_WIDE 1
`define IWD_MC_TSEL 2
`define IWD_MC_ATTR 3
`define IWD_MC_WP 4

// I/O window control bits
`define IWD_IC_EN 0
`define IWD_IC_AUTO 1
`define IWD_IC_WIDE 2
`define IWD_IC_TSEL 3

// Timing fields: setup, command, recovery in clocks minus one
`define IWD_TIM_SETUP 4:0
`define IWD_TIM_CMD 9:5
`define IWD_TIM_RECOV 14:10
`define IWD_TIM_RST 15'h0461

// 4 Kbyte pages; lowest start page is 1000h
`define IWD_PAGE_LSB 12
`define IWD_MEM_MIN_PAGE 12'h001

`endif

// File: iwd_pkg.sv
// Types shared by the window decoder files
`default_nettype none
`include "iwd_map.svh"
package iwd_pkg;

    typedef enum logic [3:0] {
        IWD_IDLE = 4'b0001,
        IWD_SETUP = 4'b0010,
        IWD_CMD = 4'b0100,
        IWD_RECOV = 4'b1000
    } iwd_state_t;

    typedef struct packed {
        logic pg_prev;
        logic strap;
        logic [`IWD_SOCKETS*`IWD_MEM_WINS-1:0][4:0] mctl;
        logic [`IWD_SOCKETS*`IWD_MEM_WINS-1:0][11:0] mstart;
        logic [`IWD_SOCKETS*`IWD_MEM_WINS-1:0][11:0] mend;
        logic [`IWD_SOCKETS*`IWD_MEM_WINS-1:0][11:0] moff;
        logic [`IWD_SOCKETS*`IWD_IO_WINS-1:0][3:0] ioctl;
        logic [`IWD_SOCKETS*`IWD_IO_WINS-1:0][15:0] iostart;
        logic [`IWD_SOCKETS*`IWD_IO_WINS-1:0][15:0] ioend;
        logic [`IWD_SOCKETS*`IWD_IO_WINS-1:0][15:0] iooff;
        logic [`IWD_SOCKETS*`IWD_TIM_SETS-1:0][14:0] tim;
        iwd_state_t state;
        logic [4:0] cnt;
        logic [23:0] caddr;
        logic cwr;
        logic cio;
        logic cattr;
        logic cwide;
        logic cauto;
        logic csock;
        logic [14:0] ctim;
        logic [15:0] rdata;
        logic done;
    } iwd_regs_t;

endpackage
`default_nettype wire

// File: iwd_mem_win.sv
// One memory window: bound check and page offset
`default_nettype none
`include "iwd_map.svh"
module iwd_mem_win (
    input wire logic [4:0] ctl_in,
    input wire logic [11:0] start_in,
    input wire logic [11:0] end_in,
    input wire logic [11:0] off_in,
    input wire logic [11:0] page_in,
    output logic hit_out,
    output logic [11:0] card_page_out
);
    // Pages below 1000h never match
    assign hit_out = ctl_in[`IWD_MC_EN] && page_in >= start_in &&
        page_in <= end_in && page_in >= `IWD_MEM_MIN_PAGE;
    assign card_page_out = page_in + off_in;
endmodule
`default_nettype wire

// File: iwd_io_win.sv
// One I/O window: byte-granular bound check and offset
`default_nettype none
`include "iwd_map.svh"
module iwd_io_win (
    input wire logic [3:0] ctl_in,
    input wire logic [15:0] start_in,
    input wire logic [15:0] end_in,
    input wire logic [15:0] off_in,
    input wire logic [15:0] addr_in,
    output logic hit_out,
    output logic [15:0] card_addr_out
);
    assign hit_out = ctl_in[`IWD_IC_EN] && addr_in >= start_in &&
        addr_in <= end_in;
    assign card_addr_out = addr_in + off_in;
endmodule
`default_nettype wire

// File: iwd_top.sv
// ISA to card window decoder: strap, registers, windows, card cycles
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "iwd_map.svh"
module iwd_top #(
    parameter bit DUAL = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic power_good_in,
    input wire logic socket_select_strap_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic host_mem_req_in,
    input wire logic host_io_req_in,
    input wire logic host_wr_in,
    input wire logic [23:0] host_addr_in,
    output logic host_claim_out,
    output logic host_busy_out,
    output logic host_done_out,
    input wire logic card_iois16_n_in,
    output logic [1:0] card_socket_out,
    output logic [23:0] card_addr_out,
    output logic card_reg_n_out,
    output logic card_oe_n_out,
    output logic card_we_n_out,
    output logic card_iord_n_out,
    output logic card_iowr_n_out,
    output logic card_wide_out
);
    localparam int NM = `IWD_SOCKETS * `IWD_MEM_WINS;
    localparam int NI = `IWD_SOCKETS * `IWD_IO_WINS;
    localparam int NT = `IWD_SOCKETS * `IWD_TIM_SETS;

    iwd_pkg::iwd_regs_t r;
    iwd_pkg::iwd_regs_t next_r;

    function automatic logic [3:0] mem_slot(input logic s,
                                           input logic [2:0] w);
        mem_slot = s ? 4'(`IWD_MEM_WINS + 32'(w)) : {1'b0, w};
    endfunction

    function automatic logic [1:0] io_slot(input logic s, input logic w);
        io_slot = {s, w};
    endfunction

    // ------------------------------------------------------------
    // Window compare
    // ------------------------------------------------------------
    logic [NM-1:0] mem_hit;
    logic [NM-1:0][11:0] mem_page;
    logic [NI-1:0] io_hit;
    logic [NI-1:0][15:0] io_addr;

    genvar gi;
    generate
        for (gi = 0; gi < NM; gi++) begin : g_mem
            logic raw;
            iwd_mem_win u_win (
                .ctl_in(r.mctl[gi]),
                .start_in(r.mstart[gi]),
                .end_in(r.mend[gi]),
                .off_in(r.moff[gi]),
                .page_in(host_addr_in[23:`IWD_PAGE_LSB]),
                .hit_out(raw),
                .card_page_out(mem_page[gi])
            );
            assign mem_hit[gi] = raw && (DUAL || gi < `IWD_MEM_WINS);
        end
        for (gi = 0; gi < NI; gi++) begin : g_io
            logic raw;
            iwd_io_win u_win (
                .ctl_in(r.ioctl[gi]),
                .start_in(r.iostart[gi]),
                .end_in(r.ioend[gi]),
                .off_in(r.iooff[gi]),
                .addr_in(host_addr_in[15:0]),
                .hit_out(raw),
                .card_addr_out(io_addr[gi])
            );
            assign io_hit[gi] = raw && (DUAL || gi < `IWD_IO_WINS);
        end
    endgenerate

    // ------------------------------------------------------------
    // Hit selection, lowest slot wins
    // ------------------------------------------------------------
    logic hit;
    logic hit_wp;
    logic hit_attr;
    logic hit_wide;
    logic hit_auto;
    logic hit_tsel;
    logic hit_sock;
    logic [23:0] hit_caddr;

    always_comb begin
        hit = 1'b0;
        hit_wp = 1'b0;
        hit_attr = 1'b0;
        hit_wide = 1'b0;
        hit_auto = 1'b0;
        hit_tsel = 1'b0;
        hit_sock = 1'b0;
        hit_caddr = 24'h000000;
        if (host_mem_req_in) begin
            for (int i = NM - 1; i >= 0; i--) begin
                if (mem_hit[i]) begin
                    hit = 1'b1;
                    hit_wp = r.mctl[i][`IWD_MC_WP];
                    hit_attr = r.mctl[i][`IWD_MC_ATTR];
                    hit_wide = r.mctl[i][`IWD_MC_WIDE];
                    hit_tsel = r.mctl[i][`IWD_MC_TSEL];
                    hit_sock = i >= `IWD_MEM_WINS;
                    hit_caddr = {mem_page[i],
                        host_addr_in[`IWD_PAGE_LSB-1:0]};
                end
            end
        end else if (host_io_req_in) begin
            for (int i = NI - 1; i >= 0; i--) begin
                if (io_hit[i]) begin
                    hit = 1'b1;
                    hit_wide = r.ioctl[i][`IWD_IC_WIDE];
                    // Fixed 16-bit overrides auto sizing
                    hit_auto = r.ioctl[i][`IWD_IC_AUTO] &&
                        !r.ioctl[i][`IWD_IC_WIDE];
                    hit_tsel = r.ioctl[i][`IWD_IC_TSEL];
                    hit_sock = i >= `IWD_IO_WINS;
                    hit_caddr = {8'h00, io_addr[i]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Register index decode
    // ------------------------------------------------------------
    logic idx_ours;
    logic idx_sock;
    logic [5:0] sub;
    logic [2:0] mw;
    logic iw;
    logic [1:0] fld;

    // Strap high claims bank 0, low claims bank 1
    assign idx_ours = (reg_addr_in[`IWD_IDX_BANK] == !r.strap) &&
        (DUAL || !reg_addr_in[`IWD_IDX_SOCK]);
    assign idx_sock = reg_addr_in[`IWD_IDX_SOCK];
    assign sub = reg_addr_in[5:0];
    assign mw = 3'(sub[4:2]);
    assign iw = 1'(3'(sub - `IWD_SUB_IO_BASE) >> 2);
    assign fld = sub[1:0];

    logic [15:0] rd_val;
    always_comb begin
        logic [3:0] m;
        logic [1:0] o;
        logic [1:0] t;
        m = mem_slot(idx_sock, mw);
        o = io_slot(idx_sock, iw);
        t = {idx_sock, sub[0]};
        rd_val = 16'h0000;
        if (!idx_ours) begin
            rd_val = 16'h0000;
        end else if (sub < `IWD_SUB_IO_BASE) begin
            if (fld == `IWD_FLD_CTL) rd_val = {11'h000, r.mctl[m]};
            else if (fld == `IWD_FLD_START) rd_val = {4'h0, r.mstart[m]};
            else if (fld == `IWD_FLD_END) rd_val = {4'h0, r.mend[m]};
            else rd_val = {4'h0, r.moff[m]};
        end else if (sub < `IWD_SUB_TIM_BASE) begin
            if (fld == `IWD_FLD_CTL) rd_val = {12'h000, r.ioctl[o]};
            else if (fld == `IWD_FLD_START) rd_val = r.iostart[o];
            else if (fld == `IWD_FLD_END) rd_val = r.ioend[o];
            else rd_val = r.iooff[o];
        end else if (sub < `IWD_SUB_STATUS) begin
            rd_val = {1'b0, r.tim[t]};
        end else if (sub == `IWD_SUB_STATUS) begin
            rd_val = {10'h000, r.strap, r.csock, r.state};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic take;
    logic drop;
    assign take = r.state == iwd_pkg::IWD_IDLE &&
        (host_mem_req_in || host_io_req_in) && hit;
    // Protected memory write: claimed, completed, no card cycle
    assign drop = take && host_mem_req_in && host_wr_in && hit_wp;

    always_comb begin
        logic [3:0] m;
        logic [1:0] o;
        logic [1:0] t;
        m = mem_slot(idx_sock, mw);
        o = io_slot(idx_sock, iw);
        t = {idx_sock, sub[0]};
        next_r = r;
        next_r.done = 1'b0;
        next_r.pg_prev = power_good_in;
        if (power_good_in && !r.pg_prev) begin
            next_r.strap = socket_select_strap_in;
        end
        next_r.rdata = reg_rd_in ? rd_val : 16'h0000;
        if (reg_wr_in && idx_ours) begin
            if (sub < `IWD_SUB_IO_BASE) begin
                if (fld == `IWD_FLD_CTL) next_r.mctl[m] = reg_wdata_in[4:0];
                else if (fld == `IWD_FLD_START)
                    next_r.mstart[m] = reg_wdata_in[11:0];
                else if (fld == `IWD_FLD_END)
                    next_r.mend[m] = reg_wdata_in[11:0];
                else next_r.moff[m] = reg_wdata_in[11:0];
            end else if (sub < `IWD_SUB_TIM_BASE) begin
                if (fld == `IWD_FLD_CTL) next_r.ioctl[o] = reg_wdata_in[3:0];
                else if (fld == `IWD_FLD_START)
                    next_r.iostart[o] = reg_wdata_in;
                else if (fld == `IWD_FLD_END) next_r.ioend[o] = reg_wdata_in;
                else next_r.iooff[o] = reg_wdata_in;
            end else if (sub < `IWD_SUB_STATUS) begin
                next_r.tim[t] = reg_wdata_in[14:0];
            end
        end
        case (r.state)
            iwd_pkg::IWD_IDLE: begin
                if (drop) begin
                    next_r.done = 1'b1;
                end else if (take) begin
                    next_r.state = iwd_pkg::IWD_SETUP;
                    next_r.caddr = hit_caddr;
                    next_r.cwr = host_wr_in;
                    next_r.cio = host_io_req_in && !host_mem_req_in;
                    next_r.cattr = hit_attr;
                    next_r.cwide = hit_wide;
                    next_r.cauto = hit_auto;
                    next_r.csock = hit_sock;
                    next_r.ctim = r.tim[{hit_sock, hit_tsel}];
                    next_r.cnt = r.tim[{hit_sock, hit_tsel}][`IWD_TIM_SETUP];
                end
            end
            iwd_pkg::IWD_SETUP: begin
                if (r.cnt == 5'h00) begin
                    next_r.state = iwd_pkg::IWD_CMD;
                    next_r.cnt = r.ctim[`IWD_TIM_CMD];
                    if (r.cauto) begin
                        next_r.cwide = !card_iois16_n_in;
                    end
                end else begin
                    next_r.cnt = r.cnt - 5'h01;
                end
            end
            iwd_pkg::IWD_CMD: begin
                if (r.cnt == 5'h00) begin
                    next_r.state = iwd_pkg::IWD_RECOV;
                    next_r.cnt = r.ctim[`IWD_TIM_RECOV];
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 5'h01;
                end
            end
            iwd_pkg::IWD_RECOV: begin
                if (r.cnt == 5'h00) next_r.state = iwd_pkg::IWD_IDLE;
                else next_r.cnt = r.cnt - 5'h01;
            end
            default: next_r.state = iwd_pkg::IWD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.strap <= 1'b1;
            r.state <= iwd_pkg::IWD_IDLE;
            r.tim <= {NT{`IWD_TIM_RST}};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic in_cmd;
    assign in_cmd = r.state == iwd_pkg::IWD_CMD;
    assign host_claim_out = take;
    assign host_busy_out = r.state != iwd_pkg::IWD_IDLE;
    assign host_done_out = r.done;
    assign reg_rdata_out = r.rdata;
    assign card_socket_out = {!r.strap, r.csock};
    assign card_addr_out = r.caddr;
    assign card_reg_n_out =
        !(host_busy_out && (r.cio || r.cattr));
    assign card_oe_n_out = !(in_cmd && !r.cio && !r.cwr);
    assign card_we_n_out = !(in_cmd && !r.cio && r.cwr);
    assign card_iord_n_out = !(in_cmd && r.cio && !r.cwr);
    assign card_iowr_n_out = !(in_cmd && r.cio && r.cwr);
    assign card_wide_out = r.cwide;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [4:0] phase_len;
    always_ff @(posedge clk_in) begin
        if (rst_in || r.state != next_r.state) phase_len <= 5'h00;
        else phase_len <= phase_len + 5'h01;
    end

    property p_strap_hold;
        @(posedge clk_in) disable iff (rst_in)
        !(power_good_in && !r.pg_prev) |=> $stable(r.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap changed without power-good edge");

    property p_strap_take;
        @(posedge clk_in) disable iff (rst_in)
        $rose(power_good_in) |-> ##1 r.strap == $past(socket_select_strap_in);
    endproperty
    a_strap_take: assert property (p_strap_take)
        else $error("strap not sampled at power-good edge");

    property p_bank_hi;
        @(posedge clk_in) disable iff (rst_in)
        reg_rd_in && r.strap && reg_addr_in[`IWD_IDX_BANK]
            |=> reg_rdata_out == 16'h0000;
    endproperty
    a_bank_hi: assert property (p_bank_hi)
        else $error("upper bank answered with strap high");

    property p_bank_lo;
        @(posedge clk_in) disable iff (rst_in)
        reg_rd_in && !r.strap && !reg_addr_in[`IWD_IDX_BANK]
            |=> reg_rdata_out == 16'h0000;
    endproperty
    a_bank_lo: assert property (p_bank_lo)
        else $error("lower bank answered with strap low");

    property p_wp_drop;
        @(posedge clk_in) disable iff (rst_in)
        drop |=> host_done_out && !host_busy_out ##1 !host_busy_out;
    endproperty
    a_wp_drop: assert property (p_wp_drop)
        else $error("protected write started a card cycle");

    property p_io_miss;
        @(posedge clk_in) disable iff (rst_in)
        host_io_req_in && !host_mem_req_in && io_hit == '0 && !host_busy_out
            |-> !host_claim_out ##1 !host_busy_out;
    endproperty
    a_io_miss: assert property (p_io_miss)
        else $error("I/O miss was claimed");

    property p_setup_len;
        @(posedge clk_in) disable iff (rst_in)
        r.state == iwd_pkg::IWD_SETUP && next_r.state == iwd_pkg::IWD_CMD
            |-> phase_len == r.ctim[`IWD_TIM_SETUP];
    endproperty
    a_setup_len: assert property (p_setup_len)
        else $error("setup length differs from timing set");

    property p_attr;
        @(posedge clk_in) disable iff (rst_in)
        in_cmd && !r.cio |-> card_reg_n_out == !r.cattr;
    endproperty
    a_attr: assert property (p_attr)
        else $error("register line disagrees with attribute bit");

    property p_auto;
        @(posedge clk_in) disable iff (rst_in)
        $rose(in_cmd) && r.cauto |-> card_wide_out == !$past(card_iois16_n_in);
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto size ignored card width signal");

    property p_offset;
        @(posedge clk_in) disable iff (rst_in)
        take && !drop |=> card_addr_out == $past(hit_caddr) && host_busy_out;
    endproperty
    a_offset: assert property (p_offset)
        else $error("card address not offset host address");

    c_mem_cycle: cover property (@(posedge clk_in) take && host_mem_req_in);
    c_io_cycle: cover property (@(posedge clk_in) take && host_io_req_in);
    c_wp_drop: cover property (@(posedge clk_in) drop);
endmodule
`default_nettype wire

// File: iwd_card_model.sv
// Behavioural inserted card that answers the 16-bit I/O decode
`default_nettype none
module iwd_card_model (
    input wire logic io16_in,
    input wire logic card_reg_n_in,
    input wire logic card_busy_in,
    output logic card_iois16_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulled up unless an I/O or attribute cycle (register line low) decodes a 16-bit port
    assign card_iois16_n_out = !(io16_in && card_busy_in &&
        !card_reg_n_in);
endmodule
`default_nettype wire

// File: iwd_top_bench.sv
// Self-checking bench for the window decoder
`default_nettype none
module iwd_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_in, pg, strap, wr, rd, mreq, ioreq, hwr, io16;
    logic [7:0] ra;
    logic [15:0] wd, rdat, g_d;
    logic [23:0] haddr, caddr, g_addr;
    logic claim, busy, done, iois_n, regn, oe_n, we_n, iord_n, iowr_n;
    logic wide, g_claim, g_done, g_busy, g_regn, g_wide;
    logic [1:0] sock, g_sock;
    int n_errors, tests_run, g_n, cyc;
    // ----------------------------------------
    // Design and card
    // ----------------------------------------
    iwd_top dut (.clk_in(clk_in), .rst_in(rst_in), .power_good_in(pg),
        .socket_select_strap_in(strap), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .host_mem_req_in(mreq), .host_io_req_in(ioreq), .host_wr_in(hwr),
        .host_addr_in(haddr), .host_claim_out(claim), .host_busy_out(busy),
        .host_done_out(done), .card_iois16_n_in(iois_n),
        .card_socket_out(sock), .card_addr_out(caddr), .card_reg_n_out(regn),
        .card_oe_n_out(oe_n), .card_we_n_out(we_n), .card_iord_n_out(iord_n),
        .card_iowr_n_out(iowr_n), .card_wide_out(wide));
    iwd_card_model card (.io16_in(io16), .card_reg_n_in(regn),
        .card_busy_in(busy), .card_iois16_n_out(iois_n));
    // ----------------------------------------
    // Bus and access tasks
    // ----------------------------------------
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk_in);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        g_d = rdat;
    endtask
    task automatic acc(input bit m, input bit w, input logic [23:0] a);
        @(posedge clk_in);
        mreq <= m;
        ioreq <= !m;
        hwr <= w;
        haddr <= a;
        @(negedge clk_in);
        g_claim = claim;
        @(posedge clk_in);
        mreq <= 1'b0;
        ioreq <= 1'b0;
        g_n = 0;
        g_done = 0;
        g_busy = 0;
        repeat (14) begin
            @(negedge clk_in);
            if (busy === 1'b1 && !g_busy) begin
                g_busy = 1;
                g_addr = caddr;
                g_regn = regn;
                g_sock = sock;
            end
            if (done === 1'b1) g_done = 1;
            // Only the strobe of this access kind counts
            if ((m && !w && oe_n === 1'b0) || (m && w && we_n === 1'b0) ||
                (!m && !w && iord_n === 1'b0) ||
                (!m && w && iowr_n === 1'b0)) begin
                g_n++;
                g_wide = wide;
            end
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rreg(8'h1c);
        check(g_d === 16'h0461, "timing default");
        rreg(8'h1f);
        check(g_d === 16'h0000, "unmapped read");
        rreg(8'h9c);
        check(g_d === 16'h0000, "other bank read");
    endtask
    task automatic t_mem;
        wreg(8'h01, 16'h0010);
        wreg(8'h02, 16'h001f);
        wreg(8'h03, 16'h0100);
        wreg(8'h00, 16'h0001);
        rreg(8'h01);
        check(g_d === 16'h0010, "start readback");
        acc(1, 0, 24'h012345);
        check(g_claim === 1'b1, "mem claim");
        check(g_addr === 24'h112345, "mem offset");
        check(g_n == 4 && g_done === 1'b1, "mem cycle");
        acc(1, 0, 24'h020000);
        check(g_claim === 1'b0 && g_n == 0, "above");
        acc(1, 0, 24'h00f000);
        check(g_claim === 1'b0 && g_n == 0, "below");
        wreg(8'h0a, 16'h0001);
        wreg(8'h08, 16'h0001);
        acc(1, 0, 24'h000800);
        check(g_claim === 1'b0, "page zero");
        acc(1, 0, 24'h001800);
        check(g_claim === 1'b1, "page one");
        wreg(8'h08, 16'h0000);
        wreg(8'h00, 16'h0000);
        acc(1, 0, 24'h012345);
        check(g_claim === 1'b0 && g_n == 0, "disabled");
    endtask
    task automatic t_attr;
        wreg(8'h5d, 16'h0020);
        wreg(8'h45, 16'h0030);
        wreg(8'h46, 16'h0030);
        wreg(8'h47, 16'h0000);
        wreg(8'h44, 16'h000d);
        acc(1, 1, 24'h030010);
        check(g_claim === 1'b1 && g_sock === 2'b01, "socket one");
        check(g_regn === 1'b0, "attribute line");
        check(g_n == 2, "timing set one");
        check(g_addr === 24'h030010, "zero offset");
    endtask
    task automatic t_wp;
        wreg(8'h00, 16'h0011);
        acc(1, 1, 24'h01f000);
        check(g_claim === 1'b1 && g_done === 1'b1, "wp claim");
        check(g_n == 0, "wp write dropped");
        acc(1, 0, 24'h01f000);
        check(g_n == 4 && g_regn === 1'b1, "wp read");
        wreg(8'h00, 16'h0000);
    endtask
    task automatic t_io;
        wreg(8'h15, 16'h03f8);
        wreg(8'h16, 16'h03ff);
        wreg(8'h17, 16'h0100);
        wreg(8'h14, 16'h0003);
        wreg(8'h19, 16'h0400);
        wreg(8'h1a, 16'h0400);
        wreg(8'h1b, 16'h0000);
        io16 <= 1'b1;
        acc(0, 0, 24'h0003fa);
        check(g_claim === 1'b1, "io claim");
        check(g_addr === 24'h0004fa, "io offset");
        check(g_n == 4 && g_wide === 1'b1, "auto wide");
        acc(0, 1, 24'h0003ff);
        check(g_claim === 1'b1 && g_n == 4, "io end bound");
        acc(0, 0, 24'h000400);
        check(g_claim === 1'b0 && g_n == 0, "io miss");
        wreg(8'h18, 16'h0001);
        acc(0, 0, 24'h000400);
        check(g_claim === 1'b1, "io win one");
        wreg(8'h14, 16'h0001);
        acc(0, 0, 24'h0003f8);
        check(g_n == 4 && g_wide === 1'b0, "fixed narrow");
        io16 <= 1'b0;
        wreg(8'h14, 16'h0003);
        acc(0, 0, 24'h0003f8);
        check(g_n == 4 && g_wide === 1'b0, "auto narrow");
        wreg(8'h14, 16'h0007);
        acc(0, 0, 24'h0003f8);
        check(g_n == 4 && g_wide === 1'b1, "fixed wide");
    endtask
    task automatic t_strap;
        @(posedge clk_in);
        pg <= 1'b0;
        strap <= 1'b0;
        repeat (3) @(posedge clk_in);
        pg <= 1'b1;
        repeat (2) @(posedge clk_in);
        strap <= 1'b1;
        rreg(8'h9e);
        check(g_d === 16'h0001, "strap low status");
        rreg(8'h1c);
        check(g_d === 16'h0000, "old bank refused");
        wreg(8'h81, 16'h0010);
        wreg(8'h82, 16'h0010);
        wreg(8'h80, 16'h0001);
        acc(1, 0, 24'h010004);
        check(g_claim === 1'b1 && g_sock === 2'b10, "socket two");
    endtask
    // ----------------------------------------
    // Clock, timeout, verdict
    // ----------------------------------------
    task automatic final_report;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        n_errors = 0; tests_run = 0; cyc = 0;
        rst_in = 1'b1; pg = 1'b1; strap = 1'b1; wr = 1'b0; rd = 1'b0;
        mreq = 1'b0; ioreq = 1'b0; hwr = 1'b0; io16 = 1'b0;
        ra = 8'h00; wd = 16'h0000; haddr = 24'h000000;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_mem();
        t_attr();
        t_wp();
        t_io();
        t_strap();
        final_report();
    end
endmodule
`default_nettype wire
